// ===== pkg/odc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface odc_link_if;
    logic sclk;    // Serial clock from controller
    logic sdin;    // Serial data, valid around falling edge
    logic sync_n;  // Frame select, active low
    modport ctl (output sclk, output sdin, output sync_n);
    modport dev (input sclk, input sdin, input sync_n);
endinterface : odc_link_if
`default_nettype wire

// ===== pkg/odc_pkg.sv
`default_nettype none
package odc_pkg;
    // Frame layout, sent most significant bit first
    localparam int FRAME_W        = 16;
    localparam int ADDR_HI        = 15;
    localparam int ADDR_LO        = 13;
    localparam int RW_BIT         = 12;
    localparam int RANGE_HI       = 10;
    localparam int RANGE_LO       = 7;
    localparam int CLEAR_LEVEL_SELECT_BIT     = 6;
    localparam int OUTPUT_ON_CTL_BIT      = 5;
    localparam int CLEAR_BIT      = 4;
    localparam int SENSE_RESISTOR_SELECT_BIT       = 3;
    localparam int SWRST_BIT      = 2;
    localparam int ADDR_W         = 3;
    localparam int RANGE_W        = 4;
    localparam int CNT_W          = 5;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_MASK  = 16'h07fc;

    // Range decode
    typedef enum logic [3:0] {
        ODC_R_4_20MA, ODC_R_0_20MA, ODC_R_0_24MA, ODC_R_PM20MA, ODC_R_PM24MA,
        ODC_R_0_5V, ODC_R_0_10V, ODC_R_PM5V, ODC_R_PM10V, ODC_R_0_6V,
        ODC_R_0_12V, ODC_R_PM6V, ODC_R_PM12V, ODC_R_PM2V5, ODC_R_NEG1V,
        ODC_R_EXT_I
    } odc_range_e;

    // Serial clock limit and controller divider
    localparam int SCLK_MAX_MHZ   = 50;
    localparam int CLK_MHZ        = 40;
    localparam int SCLK_HALF_DEF  = 4;

    // Controller register map over AHB-Lite
    localparam logic [31:0] REG_CMD    = 32'h0000_0000;
    localparam logic [31:0] REG_STATUS = 32'h0000_0004;
    localparam logic [31:0] REG_LAST   = 32'h0000_0008;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage : odc_pkg
`default_nettype wire

// ===== rtl/odc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module odc_ctrl
    import odc_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_DEF   // clk_in cycles per half serial period
) (
    input  wire logic        clk_in,      // System clock, 40 MHz
    input  wire logic        rst_n_in,    // Sync reset, active low
    input  wire logic [31:0] haddr_in,    // AHB address
    input  wire logic [1:0]  htrans_in,   // AHB transfer type
    input  wire logic        hwrite_in,   // AHB write
    input  wire logic [2:0]  hsize_in,    // AHB size
    input  wire logic [31:0] hwdata_in,   // AHB write data
    input  wire logic        hsel_in,     // AHB slave select
    input  wire logic        hready_in,   // AHB bus ready
    output logic      [31:0] hrdata_out,  // AHB read data
    output logic             hreadyout_out, // AHB ready, always high
    output logic             hresp_out,   // AHB response, always OKAY
    odc_link_if.ctl          link         // Serial link
);
    import odc_pkg::*;

    localparam int HW = (SCLK_HALF < 2) ? 2 : SCLK_HALF;

    typedef enum logic [1:0] {ODC_IDLE, ODC_LOW, ODC_HIGH, ODC_DONE} odc_st_e;
    typedef struct packed {
        odc_st_e      fsm;
        logic [15:0]  shreg;
        logic [15:0]  last;
        logic [4:0]   bits;
        logic [7:0]   div;
        logic         sclk;
        logic         sdin;
        logic         sync_n;
        logic         ph_wr;
        logic [31:0]  ph_addr;
        logic [31:0]  rdata;
    } odc_ctl_s;
    odc_ctl_s st;
    odc_ctl_s next_st;

    // Bus slave plus frame sender; clock idles high, data set on rising edge
    always_comb
    begin
        logic busy;
        next_st = st;
        busy    = (st.fsm != ODC_IDLE);
        next_st.ph_wr = 1'b0;
        if (st.ph_wr && st.ph_addr == REG_CMD && !busy)
        begin
            // are software's: the word is sent as written
            next_st.shreg  = hwdata_in[15:0];
            next_st.last   = hwdata_in[15:0];
            next_st.fsm    = ODC_LOW;
            next_st.bits   = '0;
            next_st.div    = '0;
            next_st.sync_n = 1'b0;
            next_st.sdin   = hwdata_in[15];
        end
        if (hsel_in && hready_in && htrans_in == HTRANS_NONSEQ)
        begin
            next_st.ph_wr   = hwrite_in;
            next_st.ph_addr = haddr_in;
            unique case (haddr_in)
                REG_STATUS: next_st.rdata = {31'h0, busy};
                REG_LAST:   next_st.rdata = {16'h0, st.last};
                default:    next_st.rdata = 32'h0;
            endcase
        end
        unique case (st.fsm)
            ODC_IDLE:
            begin
                next_st.sclk = 1'b1;
            end
            ODC_LOW, ODC_HIGH:
            begin
                next_st.div = st.div + 1'b1;
                if (st.div == 8'(HW - 1))
                begin
                    next_st.div = '0;
                    if (st.fsm == ODC_LOW)
                    begin
                        next_st.sclk = 1'b0;   // device samples here
                        next_st.fsm  = ODC_HIGH;
                    end
                    else
                    begin
                        next_st.sclk  = 1'b1;  // at most 10 MHz by divider
                        next_st.shreg = {st.shreg[14:0], 1'b0};
                        next_st.sdin  = st.shreg[14];
                        next_st.bits  = st.bits + 1'b1;
                        next_st.fsm   = (st.bits == 5'(FRAME_W - 1)) ? ODC_DONE : ODC_LOW;
                    end
                end
            end
            ODC_DONE:
            begin
                next_st.div = st.div + 1'b1;
                if (st.div == 8'(HW - 1))
                begin
                    next_st.sync_n = 1'b1;
                    next_st.fsm    = ODC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            st <= '{fsm: ODC_IDLE, sclk: 1'b1, sync_n: 1'b1, default: '0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign hrdata_out    = st.rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign link.sclk     = st.sclk;
    assign link.sdin     = st.sdin;
    assign link.sync_n   = st.sync_n;
endmodule : odc_ctrl
`default_nettype wire

// ===== rtl/odc_device.sv
`timescale 1ns/1ps
`default_nettype none
module odc_device
    import odc_pkg::*;
(
    input  wire logic                  clk_in,            // System clock, 40 MHz
    input  wire logic                  rst_n_in,          // Sync reset, active low
    odc_link_if.dev                    link,              // Serial link
    input  wire logic                  control_mode_strap_in, // High selects hardware mode
    input  wire logic                  hw_output_on_in,   // Hardware-mode enable pin
    input  wire logic [RANGE_W-1:0]    hw_range_in,       // Hardware-mode range pins
    input  wire logic [ADDR_W-1:0]     board_strap_in,    // Board address straps
    output logic      [15:0]           output_control_out, // Control register
    output logic      [3:0]            range_sel_out,     // Active range code
    output logic                       sense_internal_out, // Internal resistor chosen
    output logic                       current_mode_out,  // Range is a current range
    output logic                       iout_drive_out,    // Current channel driven
    output logic                       vout_drive_out,    // Voltage channel driven
    output logic                       soft_clear_out,    // Software clear level
    output logic                       soft_reset_out     // One-cycle reset pulse
);
    import odc_pkg::*;

    typedef struct packed {
        logic [15:0]        sreg;
        logic [CNT_W-1:0]   cnt;
        logic               sclk_d;
        logic               hw_mode;
        logic               mode_taken;
        logic [15:0]        ctrl;
        logic [3:0]         range;
        logic               rsel;
        logic               cur;
        logic               iout;
        logic               vout;
        logic               rst_p;
    } odc_dev_s;
    odc_dev_s st;
    odc_dev_s next_st;

    logic [2:0] pins;
    logic       sclk_s;
    logic       sdin_s;
    logic       sync_n_s;

    // Link pins cross into clk_in; 40 MHz sampling bounds the usable serial rate
    odc_sync3 #(.W(3)) u_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .d_in     ({link.sclk, link.sdin, link.sync_n}),
        .q_out    (pins)
    );
    assign sclk_s   = pins[2];
    assign sdin_s   = pins[1];
    assign sync_n_s = pins[0];

    // Range code to output kind; current ranges per resistor choice
    function automatic logic is_current(input logic rs, input logic [3:0] r);
        logic c;
        c = (r <= 4'(ODC_R_PM24MA));
        if (rs && r >= 4'(ODC_R_PM2V5))
        begin
            c = 1'b1;
        end
        return c;
    endfunction : is_current

    // Frame shifting, decode and output control
    always_comb
    begin
        logic fall;
        logic en;
        logic [15:0] f;
        en             = 1'b0;
        next_st        = st;
        fall           = st.sclk_d && !sclk_s;
        f              = {st.sreg[14:0], sdin_s};
        next_st.sclk_d = sclk_s;
        next_st.rst_p  = 1'b0;
        // Strap caught once after reset release
        if (!st.mode_taken)
        begin
            next_st.mode_taken = 1'b1;
            next_st.hw_mode    = control_mode_strap_in;
        end
        if (sync_n_s)
        begin
            next_st.cnt = '0;
        end
        else if (fall && st.cnt < CNT_W'(FRAME_W))
        begin
            next_st.sreg = f;
            next_st.cnt  = st.cnt + 1'b1;
            if (st.cnt == CNT_W'(FRAME_W - 1) && !st.hw_mode
                && f[ADDR_HI:ADDR_LO] == board_strap_in
                && !f[RW_BIT])
            begin
                next_st.ctrl = f & CTRL_MASK;
                if (f[SWRST_BIT])
                begin
                    next_st.ctrl  = CTRL_RESET;
                    next_st.rst_p = 1'b1;
                end
            end
        end
        if (st.hw_mode)
        begin
            en            = hw_output_on_in;
            next_st.range = hw_range_in;
            next_st.rsel  = 1'b0;
        end
        else
        begin
            en            = st.ctrl[OUTPUT_ON_CTL_BIT];
            next_st.range = st.ctrl[RANGE_HI:RANGE_LO];
            next_st.rsel  = st.ctrl[SENSE_RESISTOR_SELECT_BIT];
        end
        next_st.cur  = is_current(next_st.rsel, next_st.range);
        next_st.iout = en && next_st.cur;
        next_st.vout = en && !next_st.cur;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign output_control_out = st.ctrl;
    assign range_sel_out      = st.range;
    assign sense_internal_out = st.rsel;
    assign current_mode_out   = st.cur;
    assign iout_drive_out     = st.iout;
    assign vout_drive_out     = st.vout;
    assign soft_clear_out     = st.ctrl[CLEAR_BIT];
    assign soft_reset_out     = st.rst_p;
endmodule : odc_device
`default_nettype wire

// ===== rtl/odc_sync3.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; output moves only when stages two and three agree
module odc_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk_in,   // System clock
    input  wire logic         rst_n_in, // Sync reset, active low
    input  wire logic [W-1:0] d_in,     // Asynchronous inputs
    output logic      [W-1:0] q_out     // Filtered levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } odc_sync_s;
    odc_sync_s st;
    odc_sync_s next_st;

    // Per-bit agree filter
    always_comb
    begin
        next_st    = st;
        next_st.s1 = d_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st.s2[i] == st.s3[i])
            begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign q_out = st.q;
endmodule : odc_sync3
`default_nettype wire

// ===== tb/odc_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module odc_link_props #(
    parameter int SCLK_HALF = 4
) (
    input wire logic clk_in,   // System clock
    input wire logic rst_n_in, // Sync reset, active low
    input wire logic sclk,     // Serial clock
    input wire logic sdin,     // Serial data
    input wire logic sync_n    // Frame select, active low
);
    logic       sclk_q; // Previous serial clock sample
    logic [7:0] run;    // Samples at the current level
    logic [4:0] nfall;  // Falling edges in this frame
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Level lengths and bit count; the count restarts between frames
    always_ff @(posedge clk_in)
    begin
        sclk_q <= rst_n_in ? sclk : 1'b1;
        run    <= (!rst_n_in || sclk != sclk_q) ? 8'h01 : run + 8'h01;
        nfall  <= (!rst_n_in || sync_n) ? 5'h00 : nfall + 5'(sclk_q & ~sclk);
    end
    sequence bit_fall;
        !sync_n && $fell(sclk);
    endsequence
    sequence last_rise;
        nfall == 5'h10 && $rose(sclk);
    endsequence
    idle_level_a: assert property (sync_n |-> sclk)
        else $error("serial clock not idle high");
    sync_start_a: assert property ($fell(sync_n) |-> sclk && nfall == 5'h00)
        else $error("frame began badly");
    fall_in_frame_a: assert property ($fell(sclk) |-> !sync_n)
        else $error("clock edge outside frame");
    data_steady_a: assert property (!sclk |-> $stable(sdin))
        else $error("data moved while clock low");
    low_width_a: assert property (!sync_n && $rose(sclk) |-> run == 8'(SCLK_HALF))
        else $error("clock low phase wrong");
    high_width_a: assert property (bit_fall |-> nfall == 5'h00 || run == 8'(SCLK_HALF))
        else $error("clock high phase wrong");
    frame_len_a: assert property ($rose(sync_n) |-> nfall == 5'h10)
        else $error("frame not sixteen bits");
    no_extra_a: assert property (bit_fall |-> nfall < 5'h10)
        else $error("extra bit in frame");
    frame_end_a: assert property (last_rise |-> ##[1:12] $rose(sync_n))
        else $error("frame did not close");
endmodule : odc_link_props
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import odc_pkg::*;
    localparam int HALF = 4;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic        hsel = 1'b1;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        mode = 1'b0;
    logic        hw_on = 1'b0;
    logic [3:0]  hw_rng = 4'h0;
    logic [2:0]  strap = 3'h0;
    logic [15:0] outc;
    logic [15:0] outc_b;
    logic [3:0]  rsel;
    logic        sense, curm, iout, vout, sclr, srst;
    logic [31:0] s = 32'h5b;
    logic [15:0] m = 16'h0;
    int          errors = 0;
    int          checks = 0;
    int          pulses = 0;
    int          exp_p = 0;
    odc_link_if lk ();
    odc_link_if lk2 ();
    // Free-running system clock
    always #12.5 clk = ~clk;
    odc_ctrl #(.SCLK_HALF(HALF)) u_odc_ctrl (.clk_in(clk), .rst_n_in(rst_n),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hsel_in(hsel), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .link(lk));
    odc_device u_odc_device (.clk_in(clk), .rst_n_in(rst_n), .link(lk),
        .control_mode_strap_in(mode), .hw_output_on_in(hw_on), .hw_range_in(hw_rng),
        .board_strap_in(strap), .output_control_out(outc), .range_sel_out(rsel),
        .sense_internal_out(sense), .current_mode_out(curm), .iout_drive_out(iout),
        .vout_drive_out(vout), .soft_clear_out(sclr), .soft_reset_out(srst));
    // Second end, driven by the bench at its own link rate
    odc_device u_odc_device_b (.clk_in(clk), .rst_n_in(rst_n), .link(lk2),
        .control_mode_strap_in(1'b0), .hw_output_on_in(1'b0), .hw_range_in(4'h0),
        .board_strap_in(3'h5), .output_control_out(outc_b), .range_sel_out(),
        .sense_internal_out(), .current_mode_out(), .iout_drive_out(),
        .vout_drive_out(), .soft_clear_out(), .soft_reset_out());
    odc_link_props #(.SCLK_HALF(HALF)) u_odc_link_props (.clk_in(clk), .rst_n_in(rst_n),
        .sclk(lk.sclk), .sdin(lk.sdin), .sync_n(lk.sync_n));
    // Count reset pulses so none is missed between checks
    always @(posedge clk)
        if (srst === 1'b1)
            pulses++;
    function automatic logic [31:0] rnd;
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : rnd
    task automatic test_done;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Single transfer; waits on hready since the slave sets the pace
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk);
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask : ahb
    // Model of the decoded outputs; codes 13 to 15 are current only with internal sense
    task automatic vfy;
        logic c;
        c = m[10:7] <= 4'h4 || (m[3] && m[10:7] >= 4'hd);
        chk("ctrl", m, outc);
        chk("decode", {m[10:7], m[3], m[4], c}, {rsel, sense, sclr, curm});
        chk("drive", {m[5] & c, m[5] & ~c}, {iout, vout});
    endtask : vfy
    task automatic frame(input logic [2:0] a, input logic rw, input logic [8:0] f);
        logic [15:0] w;
        logic [31:0] r;
        w = {a, rw, 1'b0, f, 2'b00};
        ahb(1'b1, REG_CMD, {16'h0, w}, r);
        do ahb(1'b0, REG_STATUS, 32'h0, r); while (r[0] !== 1'b0);
        repeat (12) @(posedge clk);
        ahb(1'b0, REG_LAST, 32'h0, r);
        chk("last", w, r[15:0]);
        if (a == strap && !rw)
            m = w[2] ? 16'h0 : w & 16'h07fc;
        exp_p += int'(w[2] && a == strap && !rw);
        vfy();
        chk("pulse", exp_p, pulses);
    endtask : frame
    // Bench-made link clock, stopped outside frames
    task automatic raw(input logic [15:0] w, input int n);
        lk2.sync_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            lk2.sdin = w[15 - i];
            #100 lk2.sclk = 1'b0;
            #100 lk2.sclk = 1'b1;
        end
        #100 lk2.sync_n = 1'b1;
        lk2.sdin = ~lk2.sdin; // Released line must not keep its last bit
        #500;
    endtask : raw
    initial
    begin
        logic [31:0] x;
        lk2.sclk = 1'b1;
        lk2.sync_n = 1'b1;
        lk2.sdin = 1'b0;
        strap = rnd() & 3'h7;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        vfy();
        for (int i = 0; i < 32; i++)
        begin
            x = rnd();
            frame(strap, 1'b0, {i[3:0], x[0], 1'b1, x[1], i[4], 1'b0});
        end
        frame(strap, 1'b0, {4'h6, 5'h00});
        frame(strap, 1'b0, {4'h8, 5'h00});
        frame(strap, 1'b0, {4'h8, 5'h08});
        frame(strap ^ 3'h5, 1'b0, {4'h1, 5'h0c});
        frame(strap, 1'b1, {4'h2, 5'h0c});
        frame(strap, 1'b0, {4'h3, 5'h09});
        ahb(1'b0, 32'h10, 32'h0, x);
        chk("unmapped", 32'h0, x);
        raw(16'ha528, 8);
        chk("short", 16'h0, outc_b);
        raw(16'ha528, 16);
        chk("link2", 16'h0528, outc_b);
        mode <= 1'b1;
        hw_rng <= 4'h1;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk("hw_off", 2'b00, {iout, vout});
        hw_on <= 1'b1;
        repeat (8) @(posedge clk);
        chk("hw_cur", 2'b10, {iout, vout});
        hw_rng <= 4'h6;
        repeat (8) @(posedge clk);
        chk("hw_volt", 2'b01, {iout, vout});
        test_done();
    end
    // Run should finish well inside a millisecond
    initial
    begin
        #1000000;
        errors++;
        test_done();
    end
endmodule : tb
`default_nettype wire
